// file: erxb_params.svh
// offsets, field positions, reset values and counts for the rx buffer count / gap slice
`ifndef ERXB_PARAMS_SVH
`define ERXB_PARAMS_SVH

// register byte offsets
`define ERXB_OFS_CON1      8'h00
`define ERXB_OFS_IEN       8'h10
`define ERXB_OFS_IFLAG     8'h14
`define ERXB_OFS_RXST      8'h20
`define ERXB_OFS_STAT      8'h30
`define ERXB_OFS_GAP       8'h40
`define ERXB_OFS_GAP_CLR   8'h44
`define ERXB_OFS_GAP_SET   8'h48
`define ERXB_OFS_GAP_INV   8'h4c

// control_register_one fields
`define ERXB_CON1_ON       15
`define ERXB_CON1_DUPLEX   9
`define ERXB_CON1_AFC      8
`define ERXB_CON1_DEC      0

// ethernet_status fields
`define ERXB_STAT_CNT_LSB  16
`define ERXB_STAT_BUSY     7
`define ERXB_STAT_TX       6
`define ERXB_STAT_RX       5

// counter limits, gap reset and duplex offsets
`define ERXB_CNT_MAX       8'hff
`define ERXB_CNT_ZERO      8'h00
`define ERXB_GAP_RST       7'h12
`define ERXB_GAP_FD_OFS    8'h03
`define ERXB_GAP_HD_OFS    8'h06
`define ERXB_FIFO_DEPTH    8
`define ERXB_FIFO_WIDTH    32

`endif

// file: erxb_pkg.sv
// types shared by the rx buffer count / gap slice
package erxb_pkg;
    typedef enum logic [1:0] {
        ERXB_SZ_8  = 2'h0,
        ERXB_SZ_16 = 2'h1,
        ERXB_SZ_32 = 2'h2
    } erxb_size_t;
endpackage : erxb_pkg

// file: erxb_fifo.sv
// receive data fifo with registered output stage and registered input ready
`timescale 1ns/10ps
module erxb_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready_q,
    input  wire logic             stall,
    // drain side
    output logic [WIDTH-1:0]      out_data_q,
    output logic                  out_valid_q,
    input  wire logic             out_ready,
    // state
    output logic                  not_empty
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [AW:0]      count_q;
    logic [AW:0]      count_d;
    logic             push;
    logic             pop;

    assign push      = in_valid && in_ready_q;
    assign pop       = (count_q != '0) && (!out_valid_q || out_ready);
    assign count_d   = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign not_empty = (count_q != '0) || out_valid_q;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q   <= '0;
            rd_ptr_q   <= '0;
            count_q    <= '0;
            in_ready_q <= 1'b0;
        end else begin
            if (push) wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            if (pop)  rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            count_q    <= count_d;
            in_ready_q <= !stall && (count_d < (AW+1)'(DEPTH));
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_data_q  <= '0;
            out_valid_q <= 1'b0;
        end else if (pop) begin
            out_data_q  <= mem_q[rd_ptr_q];
            out_valid_q <= 1'b1;
        end else if (out_ready) begin
            out_valid_q <= 1'b0;
        end
    end
endmodule : erxb_fifo

// file: erxb_gap.sv
// back-to-back inter-packet gap timer counted in nibble times
`timescale 1ns/10ps
`include "erxb_params.svh"
module erxb_gap (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // timing
    input  wire logic       tx_end,
    input  wire logic       nibble_tick,
    input  wire logic [6:0] gap,
    input  wire logic       full_duplex,
    // result
    output logic            gap_ok_q
);
    logic [7:0] cnt_q;
    logic [7:0] target;

    // field holds the gap minus the duplex offset
    assign target = {1'b0, gap} + (full_duplex ? `ERXB_GAP_FD_OFS : `ERXB_GAP_HD_OFS);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q    <= '0;
            gap_ok_q <= 1'b1;
        end else if (tx_end) begin
            cnt_q    <= '0;
            gap_ok_q <= 1'b0;
        end else if (nibble_tick && !gap_ok_q) begin
            cnt_q    <= cnt_q + 8'h01;
            gap_ok_q <= (cnt_q + 8'h01) >= target;
        end
    end
endmodule : erxb_gap

// file: erxb_status.sv
// receive buffer count, busy status and inter-packet gap control slice
// ========================================================================
// Notes on behaviour
// [R1] each good packet adds the number of descriptors it used to the 8-bit count.
// [R2] software lowers the count by one per write of the decrement bit.
// [R3] an increment at 0xff leaves the count at 0xff.
// [R4] a decrement at 0x00 leaves the count at 0x00.
// [R5] an increment and a decrement in the same cycle leave the count unchanged.
// [R6] with auto flow control on, reception halts at 0xff until a decrement.
// [R7] with auto flow control off, reception goes on while the count saturates.
// [R8] packet pending is set while the count is non-zero, its interrupt only if enabled.
// [R9] any write of the rx descriptor start address clears the count.
// [R10] switching the module off does not clear the count.
// [R11] module busy reads 1 while on or still finishing work, 0 when idle.
// [R12] tx and rx active follow only their own traffic and clear when off.
// [R13] the gap field sets the minimum nibble gap; full duplex adds 3.
// [R14] in half duplex the field plus 6 is the minimum gap the transmitter keeps.
// [R15] software is expected to use 0x15 full duplex and 0x12 half duplex.
// [R16] gap register and its aliases take 16- and 32-bit accesses and ignore 8-bit ones.
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`include "erxb_params.svh"
module erxb_status
    import erxb_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire erxb_size_t  reg_size,
    output logic [31:0]      reg_rdata_q,
    // receive stream from the mac
    input  wire logic [31:0] rx_data,
    input  wire logic        rx_valid,
    output logic             rx_ready_q,
    input  wire logic        rx_frame,
    input  wire logic        rx_pkt_good,
    input  wire logic [7:0]  rx_pkt_desc,
    // receive stream to the dma
    output logic [31:0]      dma_data_q,
    output logic             dma_valid_q,
    input  wire logic        dma_ready,
    // transmit side
    input  wire logic        tx_frame,
    input  wire logic        tx_end,
    input  wire logic        nibble_tick,
    output logic             tx_gap_ok_q,
    // status out
    output logic             module_on_q,
    output logic             packet_pending_flag_q,
    output logic             pkt_pend_irq_q
);
    // ====================================================================
    // register decode
    logic        wr_con1;
    logic        wr_ien;
    logic        wr_rxst;
    logic        wr_gap;
    logic        wr_gap_clr;
    logic        wr_gap_set;
    logic        wr_gap_inv;
    logic        gap_acc_ok;
    logic        gap_hit;

    // 8-bit accesses to the gap register group fall through
    assign gap_acc_ok = (reg_size == ERXB_SZ_16) || (reg_size == ERXB_SZ_32); // R16
    assign gap_hit    = (reg_addr[7:4] == 4'(`ERXB_OFS_GAP >> 4)) && (reg_addr[1:0] == 2'h0);

    assign wr_con1    = reg_wr && (reg_addr == `ERXB_OFS_CON1);
    assign wr_ien     = reg_wr && (reg_addr == `ERXB_OFS_IEN);
    assign wr_rxst    = reg_wr && (reg_addr == `ERXB_OFS_RXST);
    assign wr_gap     = reg_wr && gap_acc_ok && (reg_addr == `ERXB_OFS_GAP);     // R16
    assign wr_gap_clr = reg_wr && gap_acc_ok && (reg_addr == `ERXB_OFS_GAP_CLR); // R16
    assign wr_gap_set = reg_wr && gap_acc_ok && (reg_addr == `ERXB_OFS_GAP_SET); // R16
    assign wr_gap_inv = reg_wr && gap_acc_ok && (reg_addr == `ERXB_OFS_GAP_INV); // R16

    // ====================================================================
    // control register one
    logic afc_q;
    logic duplex_q;
    logic dec;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            module_on_q <= 1'b0;
            afc_q       <= 1'b0;
            duplex_q    <= 1'b0;
        end else if (wr_con1) begin
            module_on_q <= reg_wdata[`ERXB_CON1_ON];
            afc_q       <= reg_wdata[`ERXB_CON1_AFC];
            duplex_q    <= reg_wdata[`ERXB_CON1_DUPLEX];
        end
    end

    // decrement bit is a write strobe, never stored
    assign dec = wr_con1 && reg_wdata[`ERXB_CON1_DEC]; // R2

    // ====================================================================
    // interrupt enable and descriptor start address
    logic        pend_ie_q;
    logic [31:0] rxst_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_ie_q <= 1'b0;
        end else if (wr_ien) begin
            pend_ie_q <= reg_wdata[0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxst_q <= '0;
        end else if (wr_rxst) begin
            rxst_q <= {reg_wdata[31:2], 2'h0};
        end
    end

    // ====================================================================
    // received buffer count
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [8:0] cnt_sum;
    logic       inc;

    assign inc     = rx_pkt_good && module_on_q && (rx_pkt_desc != 8'h00);
    assign cnt_sum = {1'b0, cnt_q} + {1'b0, rx_pkt_desc};

    always_comb begin
        cnt_d = cnt_q;
        if (wr_rxst) begin
            cnt_d = `ERXB_CNT_ZERO; // R9
        end else if (inc && dec) begin
            cnt_d = cnt_q; // R5
        end else if (inc) begin
            // saturate rather than wrap
            cnt_d = cnt_sum[8] ? `ERXB_CNT_MAX : cnt_sum[7:0]; // R1 R3 R7
        end else if (dec && (cnt_q != `ERXB_CNT_ZERO)) begin
            cnt_d = cnt_q - 8'h01; // R2 R4
        end
    end

    // switching off does not touch the count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= `ERXB_CNT_ZERO;
        end else begin
            cnt_q <= cnt_d; // R10
        end
    end

    // ====================================================================
    // packet pending flag and interrupt
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            packet_pending_flag_q <= 1'b0;
            pkt_pend_irq_q        <= 1'b0;
        end else begin
            packet_pending_flag_q <= (cnt_d != `ERXB_CNT_ZERO);               // R8
            pkt_pend_irq_q        <= (cnt_d != `ERXB_CNT_ZERO) && pend_ie_q;  // R8
        end
    end

    // ====================================================================
    // receive data fifo
    logic rx_stall;
    logic fifo_busy;

    // halt while off, or with auto flow control at max; released once a decrement drops below max
    assign rx_stall = !module_on_q || (afc_q && (cnt_d == `ERXB_CNT_MAX)); // R6 R7

    erxb_fifo #(
        .WIDTH(`ERXB_FIFO_WIDTH),
        .DEPTH(`ERXB_FIFO_DEPTH)
    ) u_fifo (
        .clk         (clk),
        .rst_n       (rst_n),
        .in_data     (rx_data),
        .in_valid    (rx_valid),
        .in_ready_q  (rx_ready_q),
        .stall       (rx_stall),
        .out_data_q  (dma_data_q),
        .out_valid_q (dma_valid_q),
        .out_ready   (dma_ready),
        .not_empty   (fifo_busy)
    );

    // ====================================================================
    // back-to-back gap register and timer
    logic [6:0] gap_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_q <= `ERXB_GAP_RST;
        end else if (wr_gap) begin
            gap_q <= reg_wdata[6:0]; // R13 R15
        end else if (wr_gap_clr) begin
            gap_q <= gap_q & ~reg_wdata[6:0];
        end else if (wr_gap_set) begin
            gap_q <= gap_q | reg_wdata[6:0];
        end else if (wr_gap_inv) begin
            gap_q <= gap_q ^ reg_wdata[6:0];
        end
    end

    erxb_gap u_gap (
        .clk         (clk),
        .rst_n       (rst_n),
        .tx_end      (tx_end),
        .nibble_tick (nibble_tick),
        .gap         (gap_q),
        .full_duplex (duplex_q),
        .gap_ok_q    (tx_gap_ok_q) // R13 R14
    );

    // ====================================================================
    // busy status
    logic tx_act_q;
    logic rx_act_q;
    logic busy_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_act_q <= 1'b0;
            rx_act_q <= 1'b0;
        end else begin
            tx_act_q <= module_on_q && tx_frame;               // R12
            rx_act_q <= module_on_q && (rx_frame || rx_valid); // R12
        end
    end

    // stays busy after switch-off while data or a frame is still in flight
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= module_on_q || fifo_busy || tx_frame || rx_frame || !tx_gap_ok_q; // R11
        end
    end

    // ====================================================================
    // read data, valid only in the cycle after the strobe
    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (reg_addr)
            `ERXB_OFS_CON1: begin
                rd_mux[`ERXB_CON1_ON]     = module_on_q;
                rd_mux[`ERXB_CON1_AFC]    = afc_q;
                rd_mux[`ERXB_CON1_DUPLEX] = duplex_q;
            end
            `ERXB_OFS_IEN: begin
                rd_mux[0] = pend_ie_q;
            end
            `ERXB_OFS_IFLAG: begin
                rd_mux[0] = packet_pending_flag_q;
            end
            `ERXB_OFS_RXST: begin
                rd_mux = rxst_q;
            end
            `ERXB_OFS_STAT: begin
                rd_mux[`ERXB_STAT_CNT_LSB +: 8] = cnt_q;
                rd_mux[`ERXB_STAT_BUSY]         = busy_q;
                rd_mux[`ERXB_STAT_TX]           = tx_act_q;
                rd_mux[`ERXB_STAT_RX]           = rx_act_q;
            end
            default: begin
                if (gap_hit && gap_acc_ok) begin
                    rd_mux[6:0] = gap_q; // R16
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= '0;
        end else if (reg_rd) begin
            reg_rdata_q <= rd_mux;
        end else begin
            reg_rdata_q <= '0;
        end
    end
endmodule : erxb_status

// file: erxb_status_asserts.sv
// concurrent checks on the ports of the rx buffer count / gap slice
`timescale 1ns/10ps
`include "erxb_params.svh"
module erxb_status_asserts
    import erxb_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire erxb_size_t  reg_size,
    input wire logic [31:0] reg_rdata_q,
    // receive and dma side
    input wire logic        rx_pkt_good,
    input wire logic [31:0] dma_data_q,
    input wire logic        dma_valid_q,
    input wire logic        dma_ready,
    // transmit gap
    input wire logic        tx_end,
    input wire logic        nibble_tick,
    input wire logic        tx_gap_ok_q,
    // status
    input wire logic        module_on_q,
    input wire logic        packet_pending_flag_q,
    input wire logic        pkt_pend_irq_q
);
    // ========================================================================
    // properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_irq;
        pkt_pend_irq_q |-> packet_pending_flag_q;
    endproperty
    a_irq: assert property (p_irq) else $error("irq without pending flag");
    property p_inc;
        $rose(packet_pending_flag_q) |-> $past(rx_pkt_good);
    endproperty
    a_inc: assert property (p_inc) else $error("pending rose without packet");
    property p_dec;
        $fell(packet_pending_flag_q) |-> $past(reg_wr);
    endproperty
    a_dec: assert property (p_dec) else $error("pending fell without write");
    property p_clr;
        reg_wr && reg_addr == `ERXB_OFS_RXST |=> !packet_pending_flag_q;
    endproperty
    a_clr: assert property (p_clr) else $error("start address write kept count");
    property p_busy;
        reg_rd && reg_addr == `ERXB_OFS_STAT && module_on_q && $past(module_on_q)
            |=> reg_rdata_q[`ERXB_STAT_BUSY];
    endproperty
    a_busy: assert property (p_busy) else $error("busy low while on");
    property p_off;
        reg_rd && reg_addr == `ERXB_OFS_STAT && !module_on_q && !$past(module_on_q)
            |=> reg_rdata_q[6:5] == 2'h0;
    endproperty
    a_off: assert property (p_off) else $error("active flags set while off");
    property p_end;
        tx_end |=> !tx_gap_ok_q;
    endproperty
    a_end: assert property (p_end) else $error("gap ok right after packet end");
    property p_tick;
        $rose(tx_gap_ok_q) |-> $past(nibble_tick);
    endproperty
    a_tick: assert property (p_tick) else $error("gap ok rose off a nibble tick");
    property p_b8;
        reg_rd && reg_size == ERXB_SZ_8 && reg_addr == `ERXB_OFS_GAP |=> reg_rdata_q == 32'h0;
    endproperty
    a_b8: assert property (p_b8) else $error("8-bit gap read not ignored");
    property p_hold;
        dma_valid_q && !dma_ready |=> dma_valid_q && $stable(dma_data_q);
    endproperty
    a_hold: assert property (p_hold) else $error("dma word dropped while stalled");
endmodule : erxb_status_asserts

bind erxb_status erxb_status_asserts u_chk (.clk, .rst_n, .reg_addr, .reg_wr, .reg_rd,
    .reg_size, .reg_rdata_q, .rx_pkt_good, .dma_data_q, .dma_valid_q, .dma_ready, .tx_end,
    .nibble_tick, .tx_gap_ok_q, .module_on_q, .packet_pending_flag_q, .pkt_pend_irq_q);

// file: erxb_mac_model.sv
// receive mac model feeding words and packet-done pulses
`timescale 1ns/10ps
module erxb_mac_model (
    // clock
    input wire logic   clk,
    // receive stream
    input wire logic   rx_ready_q,
    output logic [31:0] rx_data,
    output logic        rx_valid,
    output logic        rx_frame,
    // packet done
    output logic        rx_pkt_good,
    output logic [7:0]  rx_pkt_desc
);
    logic [31:0] q[$];

    initial begin
        rx_data = 32'h0;
        rx_valid = 1'b0;
        rx_frame = 1'b0;
        rx_pkt_good = 1'b0;
        rx_pkt_desc = 8'h0;
    end

    // word held until taken; released data toggles so it is never reused
    always @(posedge clk) begin
        if (rx_valid && rx_ready_q) begin
            void'(q.pop_front());
        end
        if (q.size() > 0) begin
            rx_valid <= 1'b1;
            rx_frame <= 1'b1;
            rx_data <= q[0];
        end else begin
            rx_valid <= 1'b0;
            rx_frame <= 1'b0;
            rx_data <= ~rx_data;
        end
    end

    task automatic good(input logic [7:0] d);
        @(posedge clk);
        rx_pkt_good <= 1'b1;
        rx_pkt_desc <= d;
        @(posedge clk);
        rx_pkt_good <= 1'b0;
        rx_pkt_desc <= ~d;
    endtask : good
endmodule : erxb_mac_model

// file: tb_top.sv
// self-checking bench for the rx buffer count / gap slice
`timescale 1ns/10ps
`include "erxb_params.svh"
module tb_top;
    import erxb_pkg::*;
    logic        clk, rst_n, reg_wr, reg_rd, rx_valid, rx_ready_q, rx_frame, rx_pkt_good;
    logic        dma_valid_q, dma_ready, tx_frame, tx_end, nibble_tick, tx_gap_ok_q, ien;
    logic        module_on_q, packet_pending_flag_q, pkt_pend_irq_q;
    logic [7:0]  reg_addr, rx_pkt_desc;
    logic [31:0] reg_wdata, reg_rdata_q, rx_data, dma_data_q, con, exp_q[$];
    erxb_size_t  reg_size;
    integer      errors, n_checks, cnt, seed;

    erxb_status u_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_size,
        .reg_rdata_q, .rx_data, .rx_valid, .rx_ready_q, .rx_frame, .rx_pkt_good, .rx_pkt_desc,
        .dma_data_q, .dma_valid_q, .dma_ready, .tx_frame, .tx_end, .nibble_tick, .tx_gap_ok_q,
        .module_on_q, .packet_pending_flag_q, .pkt_pend_irq_q);
    erxb_mac_model u_mac (.clk, .rx_ready_q, .rx_data, .rx_valid, .rx_frame, .rx_pkt_good,
        .rx_pkt_desc);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ========================================================================
    // checking and bus tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input erxb_size_t s = ERXB_SZ_32);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        reg_size <= s;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input erxb_size_t s = ERXB_SZ_32);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        reg_size <= s;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata_q, e);
    endtask : rd

    task automatic ctl(input logic [31:0] v);
        con = v;
        wr(`ERXB_OFS_CON1, v);
    endtask : ctl

    task automatic pkt(input logic [7:0] d);
        u_mac.good(d);
        if (con[`ERXB_CON1_ON]) cnt = (cnt + d > 255) ? 255 : cnt + d;
    endtask : pkt

    task automatic dec;
        wr(`ERXB_OFS_CON1, con | 32'h1);
        cnt = (cnt > 0) ? cnt - 1 : 0;
    endtask : dec

    task automatic stat(input logic b, input logic t);
        rd(`ERXB_OFS_STAT, {8'h00, cnt[7:0], 8'h00, b, t, 6'h00});
        chk({29'h0, module_on_q, pkt_pend_irq_q, packet_pending_flag_q},
            {29'h0, con[`ERXB_CON1_ON], ien && cnt != 0, cnt != 0});
    endtask : stat

    task automatic words(input int n);
        logic [31:0] w;
        repeat (n) begin
            w = $random(seed);
            u_mac.q.push_back(w);
            exp_q.push_back(w);
        end
    endtask : words

    task automatic drain;
        repeat (200) if (exp_q.size() != 0) @(posedge clk);
        chk(32'(exp_q.size()), 32'h0);
        repeat (3) @(posedge clk);
    endtask : drain

    task automatic gap_run(input int n);
        @(posedge clk);
        tx_end <= 1'b1;
        @(posedge clk);
        tx_end <= 1'b0;
        for (int i = 1; i <= n; i++) begin
            @(posedge clk);
            nibble_tick <= 1'b1;
            @(posedge clk);
            nibble_tick <= 1'b0;
            #1;
            chk({31'h0, tx_gap_ok_q}, {31'h0, i == n});
        end
    endtask : gap_run

    // dma sink stalls at random and compares every word taken
    always @(posedge clk) begin
        dma_ready <= 1'($random(seed));
        if (dma_valid_q && dma_ready) begin
            chk(dma_data_q, exp_q.size() ? exp_q.pop_front() : ~dma_data_q);
        end
    end

    initial begin
        #100000;
        errors++;
        test_done;
    end

    // ========================================================================
    // main sequence
    initial begin
        seed = 32'h003c7e69;
        errors = 0;
        n_checks = 0;
        cnt = 0;
        con = 32'h0;
        ien = 1'b0;
        rst_n = 1'b0;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        reg_size = ERXB_SZ_32;
        {tx_frame, tx_end, nibble_tick} = '0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        stat(1'b0, 1'b0);
        rd(`ERXB_OFS_GAP, 32'h12);
        rd(8'h7c, 32'h0);
        $display("test reset done");
        ctl(32'h8000);
        words(4);
        pkt(8'h03);
        drain;
        stat(1'b1, 1'b0);
        wr(`ERXB_OFS_IEN, 32'h1);
        ien = 1'b1;
        stat(1'b1, 1'b0);
        rd(`ERXB_OFS_IFLAG, 32'h1);
        repeat (4) dec;
        stat(1'b1, 1'b0);
        $display("test count done");
        pkt(8'hfe);
        pkt(8'h05);
        stat(1'b1, 1'b0);
        words(3);
        drain;
        dec;
        fork
            u_mac.good(8'h02);
            wr(`ERXB_OFS_CON1, con | 32'h1);
        join
        stat(1'b1, 1'b0);
        $display("test saturate done");
        dec;
        ctl(32'h8100);
        pkt(8'h02);
        words(2);
        repeat (20) @(posedge clk);
        chk(32'(exp_q.size()), 32'h2);
        chk({31'h0, rx_ready_q}, 32'h0);
        dec;
        drain;
        chk({31'h0, rx_ready_q}, 32'h1);
        stat(1'b1, 1'b0);
        wr(`ERXB_OFS_RXST, 32'h1000);
        cnt = 0;
        rd(`ERXB_OFS_RXST, 32'h1000);
        stat(1'b1, 1'b0);
        $display("test flow done");
        pkt(8'h07);
        tx_frame <= 1'b1;
        repeat (3) @(posedge clk);
        stat(1'b1, 1'b1);
        ctl(32'h0);
        stat(1'b1, 1'b0);
        tx_frame <= 1'b0;
        pkt(8'h04);
        dec;
        stat(1'b0, 1'b0);
        $display("test status done");
        wr(`ERXB_OFS_GAP, 32'h05, ERXB_SZ_16);
        wr(`ERXB_OFS_GAP_SET, 32'h10);
        wr(`ERXB_OFS_GAP_CLR, 32'h01);
        wr(`ERXB_OFS_GAP_INV, 32'h03);
        wr(`ERXB_OFS_GAP, 32'h00, ERXB_SZ_8);
        rd(`ERXB_OFS_GAP, 32'h17);
        rd(`ERXB_OFS_GAP_SET, 32'h17);
        rd(`ERXB_OFS_GAP, 32'h0, ERXB_SZ_8);
        for (int m = 0; m < 2; m++) begin
            ctl(m ? 32'h0 : 32'h0200);
            wr(`ERXB_OFS_GAP, m ? 32'h12 : 32'h15);
            gap_run(24);
        end
        $display("test gap done");
        test_done;
    end
endmodule : tb_top
